/* hw/rtac_crc16.v */
`timescale 1ns/1ps
`default_nettype none
`include "rtac_defines.vh"

// byte-wide crc-16, lsb first, reflected polynomial
module rtac_crc16 (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // control
  input  wire        init,
  input  wire        load,
  input  wire [7:0]  data,
  // result
  output wire [15:0] crc,
  output wire        residue_ok
);

  reg  [15:0] crc_q;
  reg  [15:0] nx;
  integer     i;

  always @* begin
    nx = crc_q ^ {8'h00, data};
    for (i = 0; i < 8; i = i + 1) begin
      if (nx[0]) begin
        nx = (nx >> 1) ^ `RTAC_CRC_POLY;
      end else begin
        nx = nx >> 1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= `RTAC_CRC_PRESET;
    end else if (init) begin
      crc_q <= `RTAC_CRC_PRESET;
    end else if (load) begin
      crc_q <= nx;
    end
  end

  assign crc        = ~crc_q;
  assign residue_ok = (crc_q == `RTAC_CRC_RESIDUE);

endmodule

`default_nettype wire

/* hw/rtac_responder.v */
`timescale 1ns/1ps
`default_nettype none
`include "rtac_defines.vh"

module rtac_responder #(
  parameter [63:0] UID_VALUE  = 64'h0123_4567_89AB_CDEF,
  parameter [7:0]  FAMILY_ID  = 8'h00,
  parameter [7:0]  DSFID      = 8'h00
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // received frame bytes and framing events
  input  wire        rx_sof,
  input  wire        rx_eof,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  // transmit frame
  output reg         tx_sof,
  output reg         tx_valid,
  output reg  [7:0]  tx_data,
  output reg         tx_eof,
  input  wire        tx_ready,
  // status
  output wire        anticoll_active
);

  localparam ST_IDLE = 3'd0;
  localparam ST_RX   = 3'd1;
  localparam ST_SLOT = 3'd2;
  localparam ST_SOF  = 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_EOF  = 3'd5;
  localparam ST_WAIT = 3'd6;

  reg  [2:0]  st_q;
  reg  [4:0]  rx_cnt_q;
  reg  [7:0]  req_flags_q;
  reg  [7:0]  cmd_q;
  reg  [7:0]  afi_q;
  integer     b;
  reg  [7:0]  mask_len_q;
  reg  [63:0] mask_q;
  reg  [3:0]  slot_number_q;
  reg         single_slot_select_q;
  reg  [3:0]  tx_idx_q;
  reg  [7:0]  tx_buf_q [0:11];
  reg  [3:0]  tx_len_q;
  reg         tx_err_q;
  reg         enable_q;
  reg         err_req_q;
  reg  [7:0]  err_code_q;
  reg  [15:0] answer_cnt_q;
  reg         rx_crc_ok_q;

  wire [4:0]  mask_byte_idx;
  wire [3:0]  mask_bytes;
  wire [4:0]  hdr_len;
  wire [4:0]  frame_len;
  wire        family_id_present;
  wire [7:0]  slot_number_bits;
  wire [63:0] uid_store;
  wire        crc_init;
  wire        crc_load;
  wire [7:0]  crc_din;
  wire [15:0] crc_val;
  wire        crc_res_ok;
  wire        apb_wr;
  wire        apb_rd;
  wire        hit;
  wire        match;
  wire [7:0]  code_checked;
  reg  [63:0] cmp_mask;
  reg  [63:0] cmp_val;
  integer     k;

  assign uid_store         = UID_VALUE;
  assign family_id_present = req_flags_q[`RTAC_REQ_FAMILY];
  assign slot_number_bits  = single_slot_select_q ? 8'd0 : 8'd4;
  assign mask_bytes        = mask_len_q[6:3] + {3'd0, |mask_len_q[2:0]};
  assign hdr_len           = family_id_present ? 5'd4 : 5'd3;
  assign mask_byte_idx     = rx_cnt_q - hdr_len;
  assign frame_len         = hdr_len + {1'b0, mask_bytes} + 5'd2;

  // compare mask: slot number above mask bits
  always @* begin
    cmp_mask = 64'h0000_0000_0000_0000;
    cmp_val  = 64'h0000_0000_0000_0000;
    for (k = 0; k < 64; k = k + 1) begin
      if (k < mask_len_q) begin
        cmp_mask[k] = 1'b1;
        cmp_val[k]  = mask_q[k];
      end else if (k < mask_len_q + slot_number_bits) begin
        cmp_mask[k] = 1'b1;
        cmp_val[k]  = slot_number_q[k - mask_len_q];
      end
    end
  end

  assign match = ((uid_store & cmp_mask) == cmp_val);

  // receive crc over whole frame, transmit crc over buffer
  assign crc_init = (st_q == ST_IDLE && rx_sof) || (st_q == ST_SLOT && rx_sof)
                    || (st_q == ST_RX && rx_sof) || (st_q == ST_SOF);
  assign crc_load = (st_q == ST_RX && rx_valid)
                    || (st_q == ST_DATA && (tx_ready || !tx_valid)
                        && tx_idx_q < tx_len_q);
  assign crc_din  = (st_q == ST_RX) ? rx_data : tx_buf_q[tx_idx_q];

  rtac_crc16 u_crc (
    .pclk       (pclk),
    .presetn    (presetn),
    .init       (crc_init),
    .load       (crc_load),
    .data       (crc_din),
    .crc        (crc_val),
    .residue_ok (crc_res_ok)
  );

  // only defined codes pass; anything else becomes generic
  assign code_checked = (err_code_q == `RTAC_ERR_OPTION ||
                         err_code_q == `RTAC_ERR_GENERIC ||
                         (err_code_q >= `RTAC_ERR_BLK_NA &&
                          err_code_q <= `RTAC_ERR_BLK_RDPROT))
                        ? err_code_q : `RTAC_ERR_GENERIC;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q                 <= ST_IDLE;
      rx_cnt_q             <= 5'd0;
      req_flags_q          <= 8'h00;
      cmd_q                <= 8'h00;
      afi_q                <= 8'h00;
      mask_len_q           <= 8'h00;
      mask_q               <= 64'h0000_0000_0000_0000;
      slot_number_q        <= 4'h0;
      single_slot_select_q <= 1'b0;
      tx_idx_q             <= 4'h0;
      tx_len_q             <= 4'h0;
      tx_err_q             <= 1'b0;
      tx_sof               <= 1'b0;
      tx_valid             <= 1'b0;
      tx_data              <= 8'h00;
      tx_eof               <= 1'b0;
      answer_cnt_q         <= 16'h0000;
      rx_crc_ok_q          <= 1'b0;
    end else begin
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
      case (st_q)
        ST_IDLE, ST_SLOT: begin
          if (rx_sof) begin
            st_q     <= ST_RX;
            rx_cnt_q <= 5'd0;
            mask_q   <= 64'h0000_0000_0000_0000;
          end else if (st_q == ST_SLOT && rx_eof) begin
            if (!single_slot_select_q &&
                slot_number_q != `RTAC_SLOT_LAST) begin
              slot_number_q <= slot_number_q + 4'h1;
              st_q          <= match_next(slot_number_q + 4'h1)
                               ? ST_SOF : ST_SLOT;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (rx_sof) begin
            rx_cnt_q <= 5'd0;
          end else if (rx_valid) begin
            if (rx_cnt_q != 5'd31) begin
              rx_cnt_q <= rx_cnt_q + 5'd1;
            end
            case (rx_cnt_q)
              5'd0: req_flags_q <= rx_data;
              5'd1: cmd_q       <= rx_data;
              default: begin
                if (family_id_present && rx_cnt_q == 5'd2) begin
                  afi_q <= rx_data;
                end else if (rx_cnt_q == hdr_len - 5'd1) begin
                  mask_len_q <= rx_data;
                end else if (rx_cnt_q >= hdr_len && mask_byte_idx < 5'd8
                             && mask_byte_idx[3:0] < mask_bytes) begin
                  mask_q[mask_byte_idx[2:0]*8 +: 8] <= rx_data;
                end
              end
            endcase
          end else if (rx_eof) begin
            rx_crc_ok_q <= crc_res_ok;
            slot_number_q        <= 4'h0;
            single_slot_select_q <= req_flags_q[`RTAC_REQ_SINGLE_SLOT];
            // malformed or bad-crc frames stay silent
            if (!crc_res_ok || !enable_q ||
                !req_flags_q[`RTAC_REQ_INVENTORY] ||
                cmd_q != `RTAC_CMD_INVENTORY ||
                mask_len_q > `RTAC_MASK_MAX ||
                rx_cnt_q != frame_len) begin
              st_q <= ST_IDLE;
            end else if (family_id_present && afi_q != FAMILY_ID) begin
              st_q <= ST_IDLE;
            end else begin
              st_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // settle slot flag before first compare
          st_q <= match ? ST_SOF : ST_SLOT;
        end
        ST_SOF: begin
          tx_sof   <= 1'b1;
          tx_idx_q <= 4'h0;
          tx_err_q <= err_req_q;
          tx_len_q <= err_req_q ? 4'd2 : 4'd10;
          tx_buf_q[0] <= err_req_q ? `RTAC_RSP_FLAGS_ERR
                                   : `RTAC_RSP_FLAGS_OK;
          tx_buf_q[1] <= err_req_q ? code_checked : DSFID;
          for (b = 0; b < 8; b = b + 1) begin
            tx_buf_q[b+2] <= uid_store[b*8 +: 8];
          end
          st_q <= ST_DATA;
        end
        ST_DATA: begin
          tx_valid <= 1'b1;
          if (tx_ready || !tx_valid) begin
            if (tx_idx_q < tx_len_q) begin
              tx_data  <= tx_buf_q[tx_idx_q];
              tx_idx_q <= tx_idx_q + 4'h1;
            end else if (tx_idx_q == tx_len_q) begin
              tx_data  <= crc_val[7:0];
              tx_idx_q <= tx_idx_q + 4'h1;
            end else if (tx_idx_q == tx_len_q + 4'h1) begin
              tx_data  <= crc_val[15:8];
              tx_idx_q <= tx_idx_q + 4'h1;
            end else begin
              tx_valid     <= 1'b0;
              st_q         <= ST_EOF;
            end
          end
        end
        ST_EOF: begin
          tx_eof       <= 1'b1;
          answer_cnt_q <= answer_cnt_q + 16'h0001;
          st_q         <= tx_err_q ? ST_IDLE : ST_SLOT;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // compare for an upcoming slot number
  function match_next;
    input [3:0] sn;
    reg   [63:0] v;
    integer j;
    begin
      v = 64'h0000_0000_0000_0000;
      for (j = 0; j < 64; j = j + 1) begin
        if (j < mask_len_q) begin
          v[j] = mask_q[j];
        end else if (j < mask_len_q + slot_number_bits) begin
          v[j] = sn[j - mask_len_q];
        end
      end
      match_next = ((uid_store & cmp_mask) == v);
    end
  endfunction

  assign anticoll_active = (st_q != ST_IDLE) && (st_q != ST_RX);

  // apb registers
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !pwrite;
  assign pready  = 1'b1;
  assign hit     = (paddr == `RTAC_ADDR_CTRL) || (paddr == `RTAC_ADDR_STATUS)
                   || (paddr == `RTAC_ADDR_UID_LO)
                   || (paddr == `RTAC_ADDR_UID_HI)
                   || (paddr == `RTAC_ADDR_ERRCODE)
                   || (paddr == `RTAC_ADDR_COUNT);
  assign pslverr = psel && penable && !hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q   <= 1'b1;
      err_req_q  <= 1'b0;
      err_code_q <= `RTAC_ERR_GENERIC;
    end else if (apb_wr) begin
      if (paddr == `RTAC_ADDR_CTRL) begin
        enable_q  <= pwdata[0];
        err_req_q <= pwdata[1];
      end else if (paddr == `RTAC_ADDR_ERRCODE) begin
        err_code_q <= pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      case (paddr)
        `RTAC_ADDR_CTRL:    prdata <= {30'd0, err_req_q, enable_q};
        `RTAC_ADDR_STATUS:  prdata <= {20'd0, slot_number_q, 1'b0, st_q,
                                       2'd0, rx_crc_ok_q, anticoll_active};
        `RTAC_ADDR_UID_LO:  prdata <= uid_store[31:0];
        `RTAC_ADDR_UID_HI:  prdata <= uid_store[63:32];
        `RTAC_ADDR_ERRCODE: prdata <= {24'd0, code_checked};
        `RTAC_ADDR_COUNT:   prdata <= {16'd0, answer_cnt_q};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

/* pkg/rtac_defines.vh */
`ifndef RTAC_DEFINES_VH
`define RTAC_DEFINES_VH

// response flags byte
`define RTAC_FLAG_ERROR_BIT   0
`define RTAC_RSP_FLAGS_OK     8'h00
`define RTAC_RSP_FLAGS_ERR    8'h01

// error codes
`define RTAC_ERR_OPTION       8'h03
`define RTAC_ERR_GENERIC      8'h0F
`define RTAC_ERR_BLK_NA       8'h10
`define RTAC_ERR_BLK_LOCKED   8'h11
`define RTAC_ERR_BLK_NOCHG    8'h12
`define RTAC_ERR_BLK_PROG     8'h13
`define RTAC_ERR_BLK_LOCK     8'h14
`define RTAC_ERR_BLK_RDPROT   8'h15

// request flag bit positions (bit n of the byte = flag n+1)
`define RTAC_REQ_INVENTORY    2
`define RTAC_REQ_FAMILY       4
`define RTAC_REQ_SINGLE_SLOT  5

// command and crc
`define RTAC_CMD_INVENTORY    8'h01
`define RTAC_CRC_PRESET       16'hFFFF
`define RTAC_CRC_POLY         16'h8408
`define RTAC_CRC_RESIDUE      16'hF0B8

// slot numbering
`define RTAC_SLOT_BITS        4
`define RTAC_SLOT_LAST        4'hF
`define RTAC_MASK_MAX         8'h40

// apb register byte addresses
`define RTAC_ADDR_CTRL        12'h000
`define RTAC_ADDR_STATUS      12'h004
`define RTAC_ADDR_UID_LO      12'h008
`define RTAC_ADDR_UID_HI      12'h00C
`define RTAC_ADDR_ERRCODE     12'h010
`define RTAC_ADDR_COUNT       12'h014

`endif

/* testbench/rtac_responder_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rtac_responder_monitor (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // frame events
  input wire logic       rx_eof,
  input wire logic       tx_sof,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_eof,
  input wire logic       tx_ready,
  input wire logic       anticoll_active
);
  logic first_q;
  logic code_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // marks flags byte, then error code byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b0;
      code_q  <= 1'b0;
    end else begin
      if (tx_sof) first_q <= 1'b1;
      else if (tx_valid && tx_ready) first_q <= 1'b0;
      if (tx_valid && tx_ready) code_q <= first_q && tx_data[0];
    end
  end
  a_flags_follow: assert property (tx_sof |=> tx_valid)
    else $error("no flags byte after frame start");
  a_flags_reserved: assert property (
    tx_sof |=> tx_data[7:1] == 7'h00) else $error("reserved flag bit set");
  a_byte_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped while stalled");
  a_eof_closes: assert property (tx_eof |-> !tx_valid && !tx_sof)
    else $error("frame end overlaps data");
  a_sof_outside: assert property (tx_valid |-> !tx_sof)
    else $error("frame start inside frame");
  a_answer_cause: assert property (
    tx_sof |-> $past(rx_eof, 2) || $past(rx_eof, 3))
    else $error("answer not tied to a slot marker");
  a_answer_active: assert property (tx_sof |-> anticoll_active)
    else $error("answer outside inventory");
  a_code_defined: assert property (
    tx_valid && code_q |-> tx_data inside
    {8'h03, 8'h0f, [8'h10:8'h15]}) else $error("undefined error code");
  c_frame: cover property (tx_eof);
  c_stall: cover property (tx_valid && !tx_ready);
  c_code: cover property (tx_valid && code_q);
endmodule
bind rtac_responder rtac_responder_monitor rtac_responder_monitor_i (
  .pclk(pclk), .presetn(presetn), .rx_eof(rx_eof), .tx_sof(tx_sof),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_eof(tx_eof),
  .tx_ready(tx_ready), .anticoll_active(anticoll_active));
`default_nettype wire

/* testbench/rtac_vcd.sv */
`timescale 1ns/1ps
`default_nettype none
module rtac_vcd (
  // clock
  input  wire logic       pclk,
  // request side
  output logic            rx_sof,
  output logic            rx_eof,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // response side
  input  wire logic       tx_sof,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eof,
  output logic            tx_ready
);
  logic       slow;
  int         nsof;
  int         nfr;
  logic [7:0] got[$];
  initial begin
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
    nsof = 0;
    nfr = 0;
  end
  // preset ones, reflected, sent complemented
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  // sink, stalls every other cycle when slow
  always @(posedge pclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_sof) nsof <= nsof + 1;
    if (tx_eof) nfr <= nfr + 1;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  task send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'd0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    @(posedge pclk);
    rx_sof <= 1'b1;
    @(posedge pclk);
    rx_sof <= 1'b0;
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_data <= ~q[i];
      @(posedge pclk);
    end
    eof();
  endtask
  task eof;
    @(posedge pclk);
    rx_eof <= 1'b1;
    @(posedge pclk);
    rx_eof <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtac_defines.vh"
module testbench;
  localparam logic [63:0] UID = 64'h1122_3344_5566_77a9;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        rx_sof, rx_eof, rx_valid, tx_sof, tx_valid, tx_eof, tx_ready;
  logic        anticoll_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  rx_data, tx_data;
  logic [7:0]  ok[$];
  int          errors, checks_done, fr0;
  rtac_responder #(.UID_VALUE(UID), .FAMILY_ID(8'h5a), .DSFID(8'h3c))
    rtac_responder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_sof(tx_sof), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_eof(tx_eof), .tx_ready(tx_ready), .anticoll_active(anticoll_active));
  rtac_vcd rtac_vcd_i (.pclk(pclk), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_sof(tx_sof),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_eof(tx_eof),
    .tx_ready(tx_ready));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_cmp(input logic [7:0] e[$]);
    logic [15:0] c;
    int k;
    c = rtac_vcd_i.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    k = 0;
    while (rtac_vcd_i.nfr == fr0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    chk(rtac_vcd_i.got.size(), e.size());
    foreach (e[i]) chk(rtac_vcd_i.got[i], e[i]);
    rtac_vcd_i.got.delete();
  endtask
  task run(input logic [7:0] q[$], input logic bad, input int n,
           input int hit, input logic [7:0] e[$]);
    int s0;
    fr0 = rtac_vcd_i.nfr;
    rtac_vcd_i.got.delete();
    for (int s = 0; s < n; s++) begin
      s0 = rtac_vcd_i.nsof;
      if (s == 0) rtac_vcd_i.send(q, bad);
      else rtac_vcd_i.eof();
      repeat (12) @(posedge pclk);
      chk(rtac_vcd_i.nsof - s0, s == hit);
      if (s == hit) wait_cmp(e);
    end
  endtask
  task t_regs;
    apb(0, `RTAC_ADDR_UID_LO, 0);
    chk(rd, UID[31:0]);
    apb(0, `RTAC_ADDR_UID_HI, 0);
    chk(rd, UID[63:32]);
    apb(0, 12'h018, 0);
    chk(er, 1'b1);
    apb(1, `RTAC_ADDR_ERRCODE, 32'h0000_0021);
    apb(0, `RTAC_ADDR_ERRCODE, 0);
    chk(rd, 32'h0000_000f);
  endtask
  task t_slots;
    rtac_vcd_i.slow = 1'b1;
    run({8'h04, 8'h01, 8'h00}, 0, 16, 9, ok);
    chk(anticoll_active, 1'b1);
    rtac_vcd_i.eof();
    repeat (4) @(posedge pclk);
    chk(anticoll_active, 1'b0);
    rtac_vcd_i.slow = 1'b0;
  endtask
  task t_mask;
    run({8'h34, 8'h01, 8'h5a, 8'h0b, 8'ha9, 8'h07}, 0, 1, 0, ok);
    run({8'h34, 8'h01, 8'h5a, 8'h0b, 8'ha9, 8'h03}, 0, 1, -1, ok);
    run({8'h34, 8'h01, 8'h5b, 8'h0b, 8'ha9, 8'h07}, 0, 1, -1, ok);
    run({8'h24, 8'h01, 8'h0b, 8'ha9, 8'h07}, 0, 1, 0, ok);
    run({8'h24, 8'h01, 8'h0b, 8'ha9, 8'h07}, 1, 1, -1, ok);
  endtask
  task t_abort;
    run({8'h04, 8'h01, 8'h04, 8'h09}, 0, 4, -1, ok);
    run({8'h04, 8'h01, 8'h04, 8'h09}, 0, 11, 10, ok);
    run({8'h24, 8'h01, 8'h00}, 0, 1, 0, ok);
  endtask
  task t_err;
    logic [7:0] cs[10];
    cs = '{8'h03, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
           8'h20, 8'h7f};
    apb(1, `RTAC_ADDR_CTRL, 32'h0000_0003);
    foreach (cs[i]) begin
      apb(1, `RTAC_ADDR_ERRCODE, {24'h00_0000, cs[i]});
      run({8'h24, 8'h01, 8'h00}, 0, 1, 0,
          {8'h01, i < 8 ? cs[i] : 8'h0f});
    end
    apb(1, `RTAC_ADDR_CTRL, 32'h0000_0000);
    run({8'h24, 8'h01, 8'h00}, 0, 1, -1, ok);
    apb(1, `RTAC_ADDR_CTRL, 32'h0000_0001);
  endtask
  task report_and_stop;
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    report_and_stop;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    checks_done = 0;
    ok = {8'h00, 8'h3c};
    for (int i = 0; i < 8; i++) ok.push_back(UID[8*i +: 8]);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_slots;
    t_mask;
    t_abort;
    t_err;
    report_and_stop;
  end
endmodule
`default_nettype wire
